//--- scs_pkg.sv
// Shared constants and types for the SMBus configuration slave
package scs_pkg;
    // Configuration byte array and serial address
    localparam int         NUM_BYTES   = 16;
    localparam logic [7:0] ADDR_BYTE   = 8'hd2;
    localparam int         CMD_MODE    = 7;
    localparam logic [3:0] BITS_BYTE   = 4'h8;
    // Retention select and output enable fields
    localparam int         OFS_RETAIN  = 0;
    localparam int         RETAIN_BIT  = 0;
    localparam int         OFS_OE      = 4;
    localparam int         OE_A_BIT    = 6;
    localparam int         OE_B_BIT    = 5;
    localparam int         OE_C_BIT    = 2;
    localparam int         OE_D_BIT    = 3;
    // Power-up values of the configuration bytes
    localparam logic [7:0] RST_BYTE0   = 8'ha1;
    localparam logic [7:0] RST_BYTE1   = 8'h85;
    localparam logic [7:0] RST_BYTE2   = 8'hff;
    localparam logic [7:0] RST_BYTE3   = 8'hff;
    localparam logic [7:0] RST_BYTE4   = 8'hed;
    localparam logic [7:0] RST_BYTE9   = 8'h25;
    localparam int         IDX_VENDOR  = 7;
    localparam int         IDX_DEVICE  = 8;
    // Avalon word map: config bytes at 0..15, status at 16
    localparam int         AV_AW       = 5;
    localparam logic [4:0] AV_STATUS   = 5'h10;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_HACK} scs_st_e;
    typedef enum logic [1:0] {R_ADDR, R_CMD, R_COUNT, R_DATA} scs_role_e;

    typedef struct packed {
        logic [2:0]                  scl;
        logic [2:0]                  sda;
        logic [1:0]                  pd;
        scs_st_e                     st;
        scs_role_e                   role;
        logic                        tx;
        logic [7:0]                  sh;
        logic [3:0]                  cnt;
        logic [6:0]                  ptr;
        logic                        blk;
        logic                        cnt_pend;
        logic                        hack;
        logic                        drv;
        logic [NUM_BYTES-1:0][7:0]   cfg;
        logic [3:0]                  oe;
        logic                        pdn;
        logic                        ack;
        logic [7:0]                  rdata;
    } scs_state_s;
endpackage : scs_pkg

//--- scs_smbus_slave.sv
// SMBus configuration slave with Avalon-MM register access
`timescale 1ns/100ps

module scs_smbus_slave #(
    parameter logic [7:0] VENDOR_BYTE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_BYTE = 8'h3c  // Arbitrary value
) (
    input  wire logic                        I_CLK,
    input  wire logic                        I_RST_B,
    input  wire logic                        I_SCL,
    input  wire logic                        I_SDA,
    output wire logic                        O_SDA,
    output wire logic                        O_SDA_OE_B,
    input  wire logic                        I_POWER_DOWN_B,
    output wire logic [3:0]                  O_OUT_ENABLE,
    output wire logic                        O_POWER_DOWN,
    input  wire logic [scs_pkg::AV_AW-1:0]   I_ADDRESS,
    input  wire logic                        I_READ,
    input  wire logic                        I_WRITE,
    input  wire logic [3:0]                  I_BYTEENABLE,
    input  wire logic [31:0]                 I_WRITEDATA,
    output wire logic [31:0]                 O_READDATA,
    output wire logic                        O_WAITREQUEST
);

    scs_pkg::scs_state_s q;
    scs_pkg::scs_state_s d;
    logic                rise;
    logic                fall;
    logic                start;
    logic                stop;
    logic                done;
    logic                load;
    logic                i2c_wr;
    logic [7:0]          b;

    // Byte indexing uses four offset bits, so the array must hold exactly sixteen bytes
    if (scs_pkg::NUM_BYTES != 16 || scs_pkg::IDX_DEVICE >= scs_pkg::NUM_BYTES) begin : g_size_check
        $error("configuration array size must be sixteen bytes");
    end

    // Power-up contents of the whole configuration array
    function automatic logic [scs_pkg::NUM_BYTES-1:0][7:0] dflt();
        logic [scs_pkg::NUM_BYTES-1:0][7:0] v;
        v = '0;
        v[0] = scs_pkg::RST_BYTE0;
        v[1] = scs_pkg::RST_BYTE1;
        v[2] = scs_pkg::RST_BYTE2;
        v[3] = scs_pkg::RST_BYTE3;
        v[4] = scs_pkg::RST_BYTE4;
        v[scs_pkg::IDX_VENDOR] = VENDOR_BYTE;
        v[scs_pkg::IDX_DEVICE] = DEVICE_BYTE;
        v[9] = scs_pkg::RST_BYTE9;
        return v;
    endfunction : dflt

    // Read of one byte; offsets past the array read as zero
    function automatic logic [7:0] cfg_rd(input logic [6:0] idx,
                                          input logic [scs_pkg::NUM_BYTES-1:0][7:0] c);
        cfg_rd = (32'(idx) < scs_pkg::NUM_BYTES) ? c[idx[3:0]] : 8'h00;
    endfunction : cfg_rd

    // Bus events from the synchronised copies; stage 0 feeds only stage 1
    assign rise  = q.scl[1] & ~q.scl[2];
    assign fall  = ~q.scl[1] & q.scl[2];
    assign start = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
    assign stop  = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
    assign done  = fall & (q.st == scs_pkg::ST_RX) & (q.cnt == scs_pkg::BITS_BYTE);

    // Next-state logic for the serial engine, config array and bus slave
    always_comb begin
        d      = q;
        load   = 1'b0;
        i2c_wr = 1'b0;
        b      = 8'h00;
        d.scl  = {q.scl[1:0], I_SCL};
        d.sda  = {q.sda[1:0], I_SDA};
        d.pd   = {q.pd[0], I_POWER_DOWN_B};
        case (q.st)
            scs_pkg::ST_RX: begin
                if (rise) begin
                    d.sh  = {q.sh[6:0], q.sda[1]};
                    d.cnt = 4'(q.cnt + 4'h1);
                end else if (done) begin
                    d.st  = scs_pkg::ST_ACK;
                    d.drv = 1'b1;
                    d.tx  = 1'b0;
                    case (q.role)
                        scs_pkg::R_ADDR: begin
                            if (q.sh[7:1] != scs_pkg::ADDR_BYTE[7:1]) begin
                                d.st  = scs_pkg::ST_IDLE;
                                d.drv = 1'b0;
                            end else if (q.sh[0]) begin
                                d.tx       = 1'b1;
                                d.cnt_pend = q.blk;
                            end else begin
                                d.role = scs_pkg::R_CMD;
                            end
                        end
                        scs_pkg::R_CMD: begin
                            // Offset bits are not checked in block mode; host keeps them zero
                            d.blk  = ~q.sh[scs_pkg::CMD_MODE];
                            d.ptr  = q.sh[scs_pkg::CMD_MODE] ? q.sh[6:0] : 7'h00;
                            d.role = q.sh[scs_pkg::CMD_MODE] ? scs_pkg::R_DATA : scs_pkg::R_COUNT;
                        end
                        scs_pkg::R_COUNT: begin
                            d.role = scs_pkg::R_DATA;
                        end
                        default: begin
                            i2c_wr = 1'b1;
                            d.ptr  = 7'(q.ptr + 7'h01);
                        end
                    endcase
                end
            end
            scs_pkg::ST_ACK: begin
                if (fall) begin
                    d.drv = 1'b0;
                    d.cnt = 4'h0;
                    d.st  = scs_pkg::ST_RX;
                    load  = q.tx;
                end
            end
            scs_pkg::ST_TX: begin
                if (fall && q.cnt == scs_pkg::BITS_BYTE) begin
                    d.st  = scs_pkg::ST_HACK; // Release for the host acknowledge
                    d.drv = 1'b0;
                    d.cnt = 4'h0;
                end else if (fall) begin
                    d.drv = ~q.sh[7];
                    d.sh  = {q.sh[6:0], 1'b0};
                    d.cnt = 4'(q.cnt + 4'h1);
                end
            end
            scs_pkg::ST_HACK: begin
                if (rise) begin
                    d.hack = ~q.sda[1];
                end else if (fall) begin
                    d.st = scs_pkg::ST_IDLE;
                    load = q.hack;
                end
            end
            default: begin
                d.drv = 1'b0;
            end
        endcase
        // Load the next byte to send: count first in block read, then data
        if (load) begin
            b          = q.cnt_pend ? 8'(scs_pkg::NUM_BYTES) : cfg_rd(q.ptr, q.cfg);
            d.st       = scs_pkg::ST_TX;
            d.drv      = ~b[7];
            d.sh       = {b[6:0], 1'b0};
            d.cnt      = 4'h1;
            d.cnt_pend = 1'b0;
            if (!q.cnt_pend) begin
                d.ptr = 7'(q.ptr + 7'h01);
            end
        end
        // Start and stop override any phase; stop keeps bytes already written
        if (start) begin
            d.st   = scs_pkg::ST_RX;
            d.role = scs_pkg::R_ADDR;
            d.cnt  = 4'h0;
            d.drv  = 1'b0;
        end else if (stop) begin
            d.st  = scs_pkg::ST_IDLE;
            d.drv = 1'b0;
        end
        // Avalon slave: one wait cycle, answer on the second
        d.ack = (I_READ | I_WRITE) & ~q.ack;
        if ((I_READ | I_WRITE) && !q.ack) begin
            if (I_ADDRESS == scs_pkg::AV_STATUS) begin
                d.rdata = {5'h00, q.blk, q.pdn, q.st != scs_pkg::ST_IDLE};
            end else begin
                d.rdata = cfg_rd({2'b00, I_ADDRESS}, q.cfg);
            end
        end
        if (I_WRITE && q.ack && I_BYTEENABLE[0] && 32'(I_ADDRESS) < scs_pkg::NUM_BYTES) begin
            d.cfg[I_ADDRESS[3:0]] = I_WRITEDATA[7:0];
        end
        // Serial write wins over a bus write to the same byte
        if (i2c_wr && 32'(q.ptr) < scs_pkg::NUM_BYTES) begin
            d.cfg[q.ptr[3:0]] = q.sh;
        end
        // Power-down clears config unless retention is selected
        if (!q.pd[1] && !q.cfg[scs_pkg::OFS_RETAIN][scs_pkg::RETAIN_BIT]) begin
            d.cfg = dflt();
        end
        d.pdn = ~q.pd[1];
        d.oe  = q.pd[1] ? {q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_D_BIT],
                           q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_C_BIT],
                           q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_B_BIT],
                           q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_A_BIT]} : 4'h0;
    end

    // State register; reset loads power-up values and an idle bus
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            q       <= '0;
            q.scl   <= 3'b111;
            q.sda   <= 3'b111;
            q.pd    <= 2'b11;
            q.cfg   <= dflt();
            q.oe    <= 4'hf;
        end else begin
            q <= d;
        end
    end

    // The pin only ever pulls low; the enable decides
    assign O_SDA         = 1'b0;
    assign O_SDA_OE_B    = ~q.drv;
    assign O_OUT_ENABLE  = q.oe;
    assign O_POWER_DOWN  = q.pdn;
    assign O_READDATA    = {24'h000000, q.rdata};
    assign O_WAITREQUEST = (I_READ | I_WRITE) & ~q.ack;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    AST_RESET_DEFAULTS:
        assert property (@(posedge I_CLK) disable iff (1'b0) !I_RST_B |=> q.cfg == dflt())
        else $error("config not at defaults after reset");
    AST_ADDR_ACK:
        assert property (done && q.role == scs_pkg::R_ADDR && q.sh == scs_pkg::ADDR_BYTE
                         |=> !O_SDA_OE_B && q.role == scs_pkg::R_CMD)
        else $error("own write address not acknowledged");
    AST_FOREIGN_ADDR:
        assert property (done && q.role == scs_pkg::R_ADDR && q.sh[7:1] != scs_pkg::ADDR_BYTE[7:1]
                         |=> O_SDA_OE_B && q.st == scs_pkg::ST_IDLE)
        else $error("foreign address acknowledged");
    AST_BYTE_OFFSET:
        assert property (done && q.role == scs_pkg::R_CMD && q.sh[7]
                         |=> q.ptr == $past(q.sh[6:0]) && !q.blk && q.role == scs_pkg::R_DATA)
        else $error("byte offset not taken from command");
    AST_BLOCK_START:
        assert property (done && q.role == scs_pkg::R_CMD && !q.sh[7]
                         |=> q.ptr == 7'h00 && q.blk && q.role == scs_pkg::R_COUNT)
        else $error("block transfer not started at offset zero");
    AST_DATA_WRITE:
        assert property (done && q.role == scs_pkg::R_DATA && q.ptr < 7'h10 && q.pd[1]
                         |=> q.cfg[$past(q.ptr[3:0])] == $past(q.sh) && q.ptr == 7'($past(q.ptr) + 7'h01)
                             && !O_SDA_OE_B)
        else $error("data byte not written or acknowledged");
    AST_STOP_RELEASE:
        assert property (stop |=> q.st == scs_pkg::ST_IDLE && O_SDA_OE_B)
        else $error("stop did not end the transfer");
    AST_PD_CLEAR:
        assert property (!q.pd[1] && !q.cfg[scs_pkg::OFS_RETAIN][scs_pkg::RETAIN_BIT] |=> q.cfg == dflt())
        else $error("config not cleared in power-down");
    AST_PD_OUTPUTS:
        assert property (!q.pd[1] |=> O_POWER_DOWN && O_OUT_ENABLE == 4'h0)
        else $error("outputs active during power-down");
    AST_OE_MAP:
        assert property (q.pd[1] |=> O_OUT_ENABLE[0] == $past(q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_A_BIT])
                                  && O_OUT_ENABLE[1] == $past(q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_B_BIT])
                                  && O_OUT_ENABLE[2] == $past(q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_C_BIT])
                                  && O_OUT_ENABLE[3] == $past(q.cfg[scs_pkg::OFS_OE][scs_pkg::OE_D_BIT]))
        else $error("output enables do not follow offset 4");
    AST_AV_ANSWER:
        assert property ((I_READ || I_WRITE) && !q.ack |-> O_WAITREQUEST ##1 !O_WAITREQUEST)
        else $error("bus answer not on second cycle");

    // Transmit side: count first in block read, then ascending bytes, each MSB first
    AST_READ_ADDR:
        assert property (done && q.role == scs_pkg::R_ADDR && q.sh == {scs_pkg::ADDR_BYTE[7:1], 1'b1}
                         |=> !O_SDA_OE_B && q.tx)
        else $error("own read address not acknowledged");
    AST_COUNT_FIRST:
        assert property (load && q.cnt_pend
                         |=> q.st == scs_pkg::ST_TX && q.ptr == $past(q.ptr) && !q.cnt_pend)
        else $error("block read did not send the count first");
    AST_READ_STEP:
        assert property (load && !q.cnt_pend
                         |=> q.st == scs_pkg::ST_TX && q.ptr == 7'($past(q.ptr) + 7'h01))
        else $error("read offset did not step upward");
    AST_TX_BIT:
        assert property (fall && q.st == scs_pkg::ST_TX && q.cnt != scs_pkg::BITS_BYTE
                         |=> O_SDA_OE_B == $past(q.sh[7]))
        else $error("transmit bit out of order");
    AST_TX_RELEASE:
        assert property (fall && q.st == scs_pkg::ST_TX && q.cnt == scs_pkg::BITS_BYTE
                         |=> q.st == scs_pkg::ST_HACK && O_SDA_OE_B)
        else $error("data line held during host acknowledge");
    AST_HOST_NACK:
        assert property (fall && q.st == scs_pkg::ST_HACK && !q.hack |=> q.st == scs_pkg::ST_IDLE && O_SDA_OE_B)
        else $error("transfer went on after host refusal");

    // Receive side and bus writes: the count stores nothing, the status word is read-only
    AST_COUNT_ACK:
        assert property (done && q.role == scs_pkg::R_COUNT
                         |=> !O_SDA_OE_B && q.role == scs_pkg::R_DATA && q.ptr == $past(q.ptr))
        else $error("byte count not acknowledged");
    AST_BUS_WRITE:
        assert property (I_WRITE && !O_WAITREQUEST && I_BYTEENABLE[0] && I_ADDRESS < scs_pkg::AV_STATUS
                         && !i2c_wr && q.pd[1] |=> q.cfg[$past(I_ADDRESS[3:0])] == $past(I_WRITEDATA[7:0]))
        else $error("bus write not stored");
    AST_STATUS_RO:
        assert property (I_WRITE && !O_WAITREQUEST && I_ADDRESS >= scs_pkg::AV_STATUS && !i2c_wr && q.pd[1]
                         |=> q.cfg == $past(q.cfg))
        else $error("write above the config bytes changed a byte");

    // Idle and power behaviour
    AST_RESET_IDLE:
        assert property (@(posedge I_CLK) disable iff (1'b0)
                         !I_RST_B |=> O_SDA_OE_B && O_OUT_ENABLE == 4'hf && !O_POWER_DOWN)
        else $error("outputs not idle after reset");
    AST_IDLE_QUIET:
        assert property (q.st == scs_pkg::ST_IDLE |=> O_SDA_OE_B)
        else $error("data line pulled while idle");
    AST_PD_LEAVE:
        assert property (q.pd[1] |=> !O_POWER_DOWN)
        else $error("power-down flag stuck after input released");
    AST_RETAIN_KEEP:
        assert property (!q.pd[1] && q.cfg[scs_pkg::OFS_RETAIN][scs_pkg::RETAIN_BIT] && !i2c_wr
                         && !(I_WRITE && !O_WAITREQUEST) |=> q.cfg == $past(q.cfg))
        else $error("config lost in power-down with retention selected");

    COV_BYTE_WRITE:   cover property (done && q.role == scs_pkg::R_DATA && !q.blk);
    COV_BLOCK_READ:   cover property (load && q.cnt_pend);
    COV_HOST_NACK:    cover property (fall && q.st == scs_pkg::ST_HACK && !q.hack);
    COV_FOREIGN:      cover property (done && q.role == scs_pkg::R_ADDR && q.sh[7:1] != scs_pkg::ADDR_BYTE[7:1]);
    COV_BLOCK_WRITE:  cover property (done && q.role == scs_pkg::R_DATA && q.blk);

endmodule : scs_smbus_slave

//--- scs_host_model.sv
// SMBus host controller model that drives the slave's clock and data pins
`timescale 1ns/100ps
module scs_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda_oe_b,
    output wire logic o_scl,
    output wire logic o_sda
);
    logic scl_q = 1'b1;
    logic rel_q = 1'b1;
    logic busy_q = 1'b0;
    // Open-drain wire with pull-up: low when either side pulls it
    assign o_sda = rel_q & i_sda_oe_b;
    assign o_scl = scl_q;
    // One phase of 8 clocks, well above the 4-clock minimum
    task automatic put(input logic c, input logic d);
        @(posedge i_clk);
        scl_q <= c;
        rel_q <= d;
        repeat (7) @(posedge i_clk);
    endtask : put
    // Clock falls first, data moves a phase later, so no false start or stop
    task automatic bit_io(input logic b, output logic seen);
        put(1'b0, rel_q);
        put(1'b0, b);
        put(1'b1, b);
        seen = o_sda;
    endtask : bit_io
    // Start, or repeated start inside a frame
    task automatic start();
        if (busy_q) begin
            put(1'b0, rel_q);
            put(1'b0, 1'b1);
            put(1'b1, 1'b1);
        end
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
        busy_q = 1'b1;
    endtask : start
    // Stop after any whole byte; clock then stands high
    task automatic stop();
        put(1'b0, rel_q);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        busy_q = 1'b0;
    endtask : stop
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wr_byte
    // Host acknowledges every byte but the last, which it refuses
    task automatic rd_byte(input logic ack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(~ack, s);
    endtask : rd_byte
endmodule : scs_host_model

//--- scs_smbus_slave_tb.sv
// Self-checking testbench of the SMBus configuration slave
`timescale 1ns/100ps
module scs_smbus_slave_tb;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             pd_b = 1'b1;
    logic [4:0]       adr = 5'h00;
    logic             rd = 1'b0;
    logic             wr = 1'b0;
    logic [31:0]      wdat = 32'h0;
    logic [3:0]       be = 4'h1;
    wire logic        sda_drv;
    wire logic        scl;
    wire logic        sda;
    wire logic        sda_oe_b;
    wire logic [3:0]  oen;
    wire logic        pdn;
    wire logic [31:0] rdat;
    wire logic        wait_req;
    int               fails = 0;
    int               tests_run = 0;
    int               cycles = 0;
    always #2.5 clk = ~clk;
    scs_host_model i_host (.i_clk(clk), .i_sda_oe_b(sda_oe_b), .o_scl(scl), .o_sda(sda));
    scs_smbus_slave i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_drv),
        .O_SDA_OE_B(sda_oe_b), .I_POWER_DOWN_B(pd_b), .O_OUT_ENABLE(oen), .O_POWER_DOWN(pdn),
        .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr), .I_BYTEENABLE(be), .I_WRITEDATA(wdat),
        .O_READDATA(rdat), .O_WAITREQUEST(wait_req));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request stands until a rising edge samples waitrequest low; read data is taken at that same edge
    task automatic av(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        rd <= ~w;
        wr <= w;
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av
    task automatic sm(input logic [7:0] v, input logic exp_ack, input string what);
        logic ack;
        i_host.wr_byte(v, ack);
        chk(what, {31'h0, exp_ack}, {31'h0, ack});
    endtask : sm
    task automatic sm_rd(input logic ack, input logic [7:0] exp, input string what);
        logic [7:0] v;
        i_host.rd_byte(ack, v);
        chk(what, {24'h0, exp}, {24'h0, v});
    endtask : sm_rd
    task automatic t_defaults();
        logic [31:0] q;
        av(1'b0, 5'h00, 8'h00, q);
        chk("byte0", 32'ha1, q);
        av(1'b0, 5'h04, 8'h00, q);
        chk("byte4", 32'hed, q);
        av(1'b0, 5'h14, 8'h00, q);
        chk("unmapped", 32'h0, q);
        av(1'b0, 5'h10, 8'h00, q);
        chk("status idle", 32'h0, q);
        av(1'b1, 5'h10, 8'hff, q);
        be <= 4'h0;
        av(1'b1, 5'h05, 8'h5a, q);
        be <= 4'h1;
        av(1'b0, 5'h10, 8'h00, q);
        chk("status kept", 32'h0, q);
        av(1'b0, 5'h05, 8'h00, q);
        chk("masked write", 32'h0, q);
        chk("drive level", 32'h0, {31'h0, sda_drv});
        chk("enables", 32'hf, {28'h0, oen});
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_byte_rw();
        i_host.start();
        sm(8'hd2, 1'b1, "addr ack");
        sm(8'h84, 1'b1, "cmd ack");
        sm(8'had, 1'b1, "data ack");
        i_host.stop();
        chk("enables", 32'he, {28'h0, oen});
        i_host.start();
        sm(8'hd2, 1'b1, "addr ack");
        sm(8'h84, 1'b1, "cmd ack");
        i_host.start();
        sm(8'hd3, 1'b1, "read addr ack");
        sm_rd(1'b0, 8'had, "byte read");
        i_host.stop();
        $display("test byte_rw done");
    endtask : t_byte_rw
    task automatic t_foreign();
        logic [31:0] q;
        i_host.start();
        sm(8'hd4, 1'b0, "foreign addr");
        sm(8'h85, 1'b0, "foreign cmd");
        sm(8'h77, 1'b0, "foreign data");
        i_host.stop();
        av(1'b0, 5'h05, 8'h00, q);
        chk("byte5", 32'h0, q);
        $display("test foreign done");
    endtask : t_foreign
    // Count claims three bytes, but the stop comes after two
    task automatic t_block_wr();
        logic [31:0] q;
        i_host.start();
        sm(8'hd2, 1'b1, "addr ack");
        sm(8'h00, 1'b1, "cmd ack");
        sm(8'h03, 1'b1, "count ack");
        sm(8'h11, 1'b1, "data0 ack");
        sm(8'h22, 1'b1, "data1 ack");
        i_host.stop();
        av(1'b0, 5'h00, 8'h00, q);
        chk("byte0", 32'h11, q);
        av(1'b0, 5'h01, 8'h00, q);
        chk("byte1", 32'h22, q);
        av(1'b0, 5'h02, 8'h00, q);
        chk("byte2", 32'hff, q);
        av(1'b0, 5'h10, 8'h00, q);
        chk("status block", 32'h4, q);
        $display("test block_wr done");
    endtask : t_block_wr
    task automatic t_block_rd();
        i_host.start();
        sm(8'hd2, 1'b1, "addr ack");
        sm(8'h00, 1'b1, "cmd ack");
        i_host.start();
        sm(8'hd3, 1'b1, "read addr ack");
        sm_rd(1'b1, 8'h10, "count");
        sm_rd(1'b1, 8'h11, "rd byte0");
        sm_rd(1'b1, 8'h22, "rd byte1");
        sm_rd(1'b0, 8'hff, "rd byte2");
        i_host.stop();
        $display("test block_rd done");
    endtask : t_block_rd
    // Serial port stays quiet around power-down, as a running system must
    task automatic t_power();
        logic [31:0] q;
        pd_b <= 1'b0;
        repeat (6) @(posedge clk);
        chk("power down", 32'h1, {31'h0, pdn});
        chk("enables off", 32'h0, {28'h0, oen});
        av(1'b0, 5'h10, 8'h00, q);
        chk("status power down", 32'h6, q);
        pd_b <= 1'b1;
        repeat (6) @(posedge clk);
        chk("kept enables", 32'he, {28'h0, oen});
        av(1'b1, 5'h00, 8'h10, q);
        pd_b <= 1'b0;
        repeat (6) @(posedge clk);
        pd_b <= 1'b1;
        repeat (6) @(posedge clk);
        chk("power up", 32'h0, {31'h0, pdn});
        av(1'b0, 5'h00, 8'h00, q);
        chk("cleared byte0", 32'ha1, q);
        chk("cleared enables", 32'hf, {28'h0, oen});
        $display("test power done");
    endtask : t_power
    task automatic give_verdict();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // Whole run takes about 5200 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_defaults();
        t_byte_rw();
        t_foreign();
        t_block_wr();
        t_block_rd();
        t_power();
        give_verdict();
    end
endmodule : scs_smbus_slave_tb
